//--- verilog/cmsp_defs.svh
`ifndef CMSP_DEFS_SVH
`define CMSP_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CMSP_ADDR_W     4
`define CMSP_OFS_CTRL   4'h0
`define CMSP_OFS_GATE   4'h4
`define CMSP_OFS_STAT   4'h8

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CMSP_CTRL_FREE  0
`define CMSP_CTRL_PSTOP 1
`define CMSP_CTRL_RST   2'h0
`define CMSP_GATE_RST   8'h00

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define CMSP_MODE_SC    2'h0
`define CMSP_MODE_SSC   2'h1
`define CMSP_MODE_EXP   2'h2

`endif

//--- verilog/cmsp_pkg.sv
package cmsp_pkg;

  typedef enum logic [1:0]
  {
    CMSP_RUN   = 2'b00,
    CMSP_WAIT  = 2'b01,
    CMSP_PSTOP = 2'b10,
    CMSP_STOP  = 2'b11
  } cmsp_pwr_e;

  typedef struct packed
  {
    logic osc_en;
    logic core_clk_en;
    logic tick_wdog_en;
    logic periph_en;
    logic core_bus_hold;
  } cmsp_clk_s;

endpackage : cmsp_pkg

//--- verilog/cmsp_ctrl.sv
// Our own choices: the register offsets and the Wishbone interface to the registers.
`include "cmsp_defs.svh"

// How it works
// - In expanded mode with enable set, flag free cycles when core leaves bus idle
// - Capture oscillator-select strap at rising edge of the reset pin
// - Captured low selects external clock or Pierce crystal on oscillator input
// - Captured high selects low-power Colpitts oscillator across both pins
// - Pull-up on oscillator-select strap while reset is held
// - Secured part reset into expanded mode disables internal flash and EEPROM
// - Secured part reset into expanded mode refuses all debug port requests
// - Backdoor key access also unsecures the part
// - Reset into special single-chip verifies erasure before security reprogramming
// - Debug port may write mode bits, e.g. to switch to expanded mode
// - Any reset before security bits are unsecured returns part to secured
// - Full stop halts every clock and the oscillator
// - Full stop exits only on reset or external interrupt
// - Pseudo-stop keeps oscillator, tick and watchdog; other peripherals off
// - Wait stops execution and holds core buses static
// - Wait keeps peripherals clocked, each may gate its own clock
module cmsp_ctrl #(
  parameter int NPERIPH = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               reset_pin_n_i,
  input  wire logic               osc_type_strap_n_i,
  input  wire logic [1:0]         mode_strap_i,
  output logic                    strap_pullup_o,
  output logic                    osc_colpitts_o,
  output logic                    osc_pierce_ext_o,
  input  wire logic               core_bus_busy_i,
  output logic                    free_cycle_indicator_o,
  input  wire logic               fsec_unsecured_i,
  input  wire logic               nvm_erased_i,
  input  wire logic               backdoor_key_ok_i,
  output logic                    secured_o,
  output logic                    nvm_enable_o,
  output logic                    sec_prog_allow_o,
  input  wire logic               dbg_req_i,
  input  wire logic               dbg_mode_we_i,
  input  wire logic [1:0]         dbg_mode_i,
  output logic                    dbg_ack_o,
  output logic                    dbg_refused_o,
  output logic [1:0]              mode_o,
  input  wire logic               stop_instr_i,
  input  wire logic               wait_instruction_i,
  input  wire logic               ext_irq_i,
  input  wire logic               tick_wdog_wake_i,
  input  wire logic               irq_i,
  output cmsp_pkg::cmsp_clk_s     clk_ctl_o,
  output logic [NPERIPH-1:0]      periph_clk_en_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic                 pin_q;
  logic [1:0]           ctrl;
  logic [NPERIPH-1:0]   gate;
  logic                 boot_exp;
  logic                 boot_ssc;
  logic                 erase_ok;
  logic                 secured;
  cmsp_pkg::cmsp_pwr_e  pwr;
  cmsp_pkg::cmsp_pwr_e  next_pwr;
  cmsp_pkg::cmsp_pwr_e  pwr_d;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire in_reset  = rst_i | ~reset_pin_n_i;
  wire pin_rise  = reset_pin_n_i & ~pin_q;
  wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl  = wb_adr_i == `CMSP_OFS_CTRL;
  wire hit_gate  = wb_adr_i == `CMSP_OFS_GATE;
  wire hit_stat  = wb_adr_i == `CMSP_OFS_STAT;
  wire is_exp    = mode_o == `CMSP_MODE_EXP;
  wire dbg_lock  = (secured & boot_exp) | pin_rise;
  wire [31:0] stat_word = {24'h000000, pwr, erase_ok, boot_exp, mode_o, secured, osc_colpitts_o};
  wire [31:0] rd_word;

  assign rd_word = hit_ctrl ? {30'h00000000, ctrl}
                 : hit_gate ? {{(32 - NPERIPH){1'b0}}, gate}
                 : hit_stat ? stat_word
                 : 32'h00000000;

  // Unmapped addresses still ack, reading zero, so the master never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `CMSP_CTRL_RST;
      gate <= NPERIPH'(`CMSP_GATE_RST);
    end
    else if (wb_wr & hit_ctrl)
      ctrl <= wb_dat_i[1:0];
    else if (wb_wr & hit_gate)
      gate <= wb_dat_i[NPERIPH-1:0];
  end

  // ----------------------------------------
  // Reset pin straps
  // ----------------------------------------
  // pull-up in reset; edge detector idles high so rst_i release is no false edge
  always_ff @(posedge clk_i)
  begin
    strap_pullup_o <= in_reset;
    pin_q          <= rst_i | reset_pin_n_i;
  end
  // strap capture; held between edges; oscillator type
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_colpitts_o   <= 1'b1;
      osc_pierce_ext_o <= 1'b0;
    end
    else if (pin_rise)
    begin
      osc_colpitts_o   <= osc_type_strap_n_i;
      osc_pierce_ext_o <= ~osc_type_strap_n_i;
    end
  end
  // debug writes mode bits; refused when locked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_o   <= `CMSP_MODE_SC;
      boot_exp <= 1'b0;
      boot_ssc <= 1'b0;
    end
    else if (pin_rise)
    begin
      mode_o   <= mode_strap_i;
      boot_exp <= mode_strap_i == `CMSP_MODE_EXP;
      boot_ssc <= mode_strap_i == `CMSP_MODE_SSC;
    end
    else if (dbg_req_i & dbg_mode_we_i & ~dbg_lock & ~in_reset)
      mode_o <= dbg_mode_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dbg_ack_o     <= 1'b0;
      dbg_refused_o <= 1'b0;
    end
    else
    begin
      dbg_ack_o     <= dbg_req_i & ~dbg_lock & ~in_reset;
      dbg_refused_o <= dbg_req_i & (dbg_lock | in_reset);
    end
  end

  // ----------------------------------------
  // Security
  // ----------------------------------------
  // reset resecures; backdoor; erased part unsecured by its bits
  always_ff @(posedge clk_i)
  begin
    if (in_reset)
      secured <= 1'b1;
    else if (fsec_unsecured_i | backdoor_key_ok_i)
      secured <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (in_reset)
      erase_ok <= 1'b0;
    else if (boot_ssc & nvm_erased_i)
      erase_ok <= 1'b1;
  end
  // flash and EEPROM off when secured expanded boot, and in the capture cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      secured_o        <= 1'b1;
      nvm_enable_o     <= 1'b0;
      sec_prog_allow_o <= 1'b0;
    end
    else
    begin
      secured_o        <= secured;
      nvm_enable_o     <= ~dbg_lock & ~in_reset;
      sec_prog_allow_o <= erase_ok & ~in_reset;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      free_cycle_indicator_o <= 1'b0;
    else
      free_cycle_indicator_o <= is_exp & ctrl[`CMSP_CTRL_FREE] & ~core_bus_busy_i & ~in_reset;
  end

  // ----------------------------------------
  // Low-power sequencer
  // ----------------------------------------
  always_comb
  begin
    next_pwr = pwr;
    case (pwr)
      cmsp_pkg::CMSP_RUN:
        if (stop_instr_i)
          next_pwr = ctrl[`CMSP_CTRL_PSTOP] ? cmsp_pkg::CMSP_PSTOP : cmsp_pkg::CMSP_STOP;
        else if (wait_instruction_i)
          next_pwr = cmsp_pkg::CMSP_WAIT;
      cmsp_pkg::CMSP_WAIT:
        if (irq_i | ext_irq_i)
          next_pwr = cmsp_pkg::CMSP_RUN;
      cmsp_pkg::CMSP_PSTOP:
        if (ext_irq_i | tick_wdog_wake_i)
          next_pwr = cmsp_pkg::CMSP_RUN;
      // only external interrupt, reset handled below
      cmsp_pkg::CMSP_STOP:
        if (ext_irq_i)
          next_pwr = cmsp_pkg::CMSP_RUN;
      default:
        next_pwr = cmsp_pkg::CMSP_RUN;
    endcase
  end
  // Either reset forces run, so state and clock enables never disagree
  assign pwr_d = in_reset ? cmsp_pkg::CMSP_RUN : next_pwr;
  always_ff @(posedge clk_i)
  begin
    pwr <= pwr_d;
  end
  always_ff @(posedge clk_i)
  begin
    clk_ctl_o.osc_en        <= pwr_d != cmsp_pkg::CMSP_STOP;
    clk_ctl_o.core_clk_en   <= pwr_d == cmsp_pkg::CMSP_RUN;
    clk_ctl_o.tick_wdog_en  <= pwr_d != cmsp_pkg::CMSP_STOP;
    clk_ctl_o.periph_en     <= pwr_d == cmsp_pkg::CMSP_RUN || pwr_d == cmsp_pkg::CMSP_WAIT;
    clk_ctl_o.core_bus_hold <= pwr_d != cmsp_pkg::CMSP_RUN;
    // Gating only honoured in wait so a stale mask cannot starve run mode
    if (pwr_d == cmsp_pkg::CMSP_WAIT)
      periph_clk_en_o <= ~gate;
    else if (pwr_d == cmsp_pkg::CMSP_RUN)
      periph_clk_en_o <= {NPERIPH{1'b1}};
    else
      periph_clk_en_o <= {NPERIPH{1'b0}};
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb_chk @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_free;
    free_cycle_indicator_o |-> $past(is_exp & ctrl[`CMSP_CTRL_FREE] & ~core_bus_busy_i);
  endproperty
  a_free: assert property (p_free) else $error("free cycle flag without cause");
  property p_strap;
    pin_rise |=> osc_colpitts_o == $past(osc_type_strap_n_i) && osc_pierce_ext_o != osc_colpitts_o;
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");
  property p_hold;
    !$past(pin_rise) |-> $stable(osc_colpitts_o);
  endproperty
  a_hold: assert property (p_hold) else $error("oscillator type changed");
  property p_pull;
    ~reset_pin_n_i |=> strap_pullup_o;
  endproperty
  a_pull: assert property (p_pull) else $error("no pull-up in reset");
  property p_nvm;
    secured & boot_exp |=> !nvm_enable_o;
  endproperty
  a_nvm: assert property (p_nvm) else $error("nvm enabled when locked");
  property p_dbg;
    dbg_req_i & dbg_lock |=> dbg_refused_o && !dbg_ack_o;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug not refused");
  property p_resec;
    disable iff (1'b0) in_reset |=> ##1 secured_o;
  endproperty
  a_resec: assert property (p_resec) else $error("reset did not resecure");
  property p_stop;
    pwr == cmsp_pkg::CMSP_STOP |-> !clk_ctl_o.osc_en && !clk_ctl_o.core_clk_en;
  endproperty
  a_stop: assert property (p_stop) else $error("clock alive in stop");
  property p_stopx;
    pwr == cmsp_pkg::CMSP_STOP && !ext_irq_i && !in_reset |=> pwr == cmsp_pkg::CMSP_STOP;
  endproperty
  a_stopx: assert property (p_stopx) else $error("stop left without wake");
  property p_pstop;
    pwr == cmsp_pkg::CMSP_PSTOP |-> clk_ctl_o.osc_en && clk_ctl_o.tick_wdog_en && !clk_ctl_o.periph_en;
  endproperty
  a_pstop: assert property (p_pstop) else $error("pseudo-stop clocks wrong");
  property p_wait;
    pwr == cmsp_pkg::CMSP_WAIT |-> clk_ctl_o.core_bus_hold && !clk_ctl_o.core_clk_en;
  endproperty
  a_wait: assert property (p_wait) else $error("wait core not held");
  property p_wgate;
    pwr == cmsp_pkg::CMSP_WAIT |-> clk_ctl_o.periph_en && periph_clk_en_o == ~$past(gate);
  endproperty
  a_wgate: assert property (p_wgate) else $error("wait gating wrong");
  property p_ack;
    wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");

  c_stop: cover property (@(posedge clk_i) pwr == cmsp_pkg::CMSP_STOP ##[1:20] pwr == cmsp_pkg::CMSP_RUN);
  c_wait: cover property (@(posedge clk_i) pwr == cmsp_pkg::CMSP_WAIT);
  c_dbg:  cover property (@(posedge clk_i) dbg_refused_o);
  c_uns:  cover property (@(posedge clk_i) secured_o ##1 !secured_o);

endmodule : cmsp_ctrl

//--- tb/cmsp_far_model.sv
// ----------------------------------------
// Debug host and memory eraser
// ----------------------------------------
module cmsp_far_model (
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  input  wire logic       refused_i,
  output logic            req_o,
  output logic            we_o,
  output logic [1:0]      mode_o,
  output logic            erased_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_o = 1'b0;
    we_o = 1'b0;
    mode_o = 2'h0;
    erased_o = 1'b0;
  end
  task erase(input logic e);
    erased_o <= e;
  endtask : erase
  // Released mode lines show the inverse, so stale data never looks valid
  task op(input logic we, input logic [1:0] md, output logic [1:0] res);
    res = 2'h0;
    req_o <= 1'b1;
    we_o <= we;
    mode_o <= md;
    @(posedge clk_i);
    req_o <= 1'b0;
    we_o <= 1'b0;
    mode_o <= ~md;
    repeat (4)
    begin
      @(posedge clk_i);
      if (res == 2'h0)
        res = {ack_i, refused_i};
    end
  endtask : op
endmodule : cmsp_far_model

//--- tb/tb_chip_mode_security_power_ctrl.sv
`include "cmsp_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_chip_mode_security_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reset_pin_n_i, osc_type_strap_n_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, seed;
  logic [1:0] mode_strap_i, dbg_mode_i, mode_o, r;
  logic core_bus_busy_i, fsec_unsecured_i, nvm_erased_i, backdoor_key_ok_i, dbg_req_i, dbg_mode_we_i;
  logic stop_instr_i, wait_instruction_i, ext_irq_i, tick_wdog_wake_i, irq_i, b;
  logic strap_pullup_o, osc_colpitts_o, osc_pierce_ext_o, free_cycle_indicator_o, secured_o;
  logic nvm_enable_o, sec_prog_allow_o, dbg_ack_o, dbg_refused_o;
  logic [7:0] periph_clk_en_o, g;
  cmsp_pkg::cmsp_clk_s clk_ctl_o;
  int miscompares, tests_run;
  cmsp_ctrl #(.NPERIPH(8)) cmsp_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .reset_pin_n_i, .osc_type_strap_n_i, .mode_strap_i,
    .strap_pullup_o, .osc_colpitts_o, .osc_pierce_ext_o, .core_bus_busy_i, .free_cycle_indicator_o,
    .fsec_unsecured_i, .nvm_erased_i, .backdoor_key_ok_i, .secured_o, .nvm_enable_o, .sec_prog_allow_o,
    .dbg_req_i, .dbg_mode_we_i, .dbg_mode_i, .dbg_ack_o, .dbg_refused_o, .mode_o, .stop_instr_i,
    .wait_instruction_i, .ext_irq_i, .tick_wdog_wake_i, .irq_i, .clk_ctl_o, .periph_clk_en_o);
  cmsp_far_model cmsp_far_model_inst (.clk_i, .ack_i(dbg_ack_o), .refused_i(dbg_refused_o),
    .req_o(dbg_req_i), .we_o(dbg_mode_we_i), .mode_o(dbg_mode_i), .erased_o(nvm_erased_i));
  always #25 clk_i = ~clk_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Ack is sampled at the edge itself, so read data is taken before it can move
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 8)
    begin
      @(posedge clk_i);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n == 8)
    begin
      miscompares++;
      close_out();
    end
  endtask : wb
  task boot(input logic [1:0] md, input logic s);
    reset_pin_n_i <= 1'b0;
    mode_strap_i <= md;
    osc_type_strap_n_i <= s;
    cyc(3);
    `CHK("pullup", 1'b1, strap_pullup_o)
    reset_pin_n_i <= 1'b1;
    cyc(6);
    `CHK("pullrel", 1'b0, strap_pullup_o)
  endtask : boot
  task instr(input logic w);
    if (w)
      wait_instruction_i <= 1'b1;
    else
      stop_instr_i <= 1'b1;
    cyc(1);
    stop_instr_i <= 1'b0;
    wait_instruction_i <= 1'b0;
    cyc(3);
  endtask : instr
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, core_bus_busy_i, fsec_unsecured_i, backdoor_key_ok_i} = '0;
    {stop_instr_i, wait_instruction_i, ext_irq_i, tick_wdog_wake_i, irq_i, reset_pin_n_i} = '0;
    {rst_i, osc_type_strap_n_i, wb_sel_i, wb_adr_i, wb_dat_i, mode_strap_i} = {2'b11, 4'hf, 38'h0};
    seed = 32'd35544;
    miscompares = 0;
    tests_run = 0;
    cyc(5);
    rst_i <= 1'b0;
    wb(1'b0, `CMSP_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'(`CMSP_CTRL_RST), q)
    wb(1'b0, `CMSP_OFS_GATE, 32'h0);
    `CHK("gate", 32'(`CMSP_GATE_RST), q)
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, q)
    boot(`CMSP_MODE_EXP, 1'b0);
    `CHK("colpitts", 1'b0, osc_colpitts_o)
    `CHK("pierce", 1'b1, osc_pierce_ext_o)
    `CHK("nvm", 1'b0, nvm_enable_o)
    cmsp_far_model_inst.op(1'b1, `CMSP_MODE_SC, r);
    `CHK("dbg", 2'b01, r)
    `CHK("mode", `CMSP_MODE_EXP, mode_o)
    osc_type_strap_n_i <= 1'b1;
    cyc(4);
    `CHK("held", 1'b0, osc_colpitts_o)
    wb(1'b1, `CMSP_OFS_CTRL, 32'h1);
    repeat (16)
    begin
      b = rnd() % 2;
      core_bus_busy_i <= b;
      cyc(2);
      `CHK("free", ~b, free_cycle_indicator_o)
    end
    backdoor_key_ok_i <= 1'b1;
    cyc(1);
    backdoor_key_ok_i <= 1'b0;
    cyc(3);
    `CHK("unsec", 1'b0, secured_o)
    boot(`CMSP_MODE_EXP, 1'b1);
    `CHK("resec", 1'b1, secured_o)
    `CHK("colp", 1'b1, osc_colpitts_o)
    cmsp_far_model_inst.erase(1'b1);
    boot(`CMSP_MODE_SSC, 1'b1);
    `CHK("progok", 1'b1, sec_prog_allow_o)
    `CHK("nvmon", 1'b1, nvm_enable_o)
    cmsp_far_model_inst.op(1'b1, `CMSP_MODE_EXP, r);
    `CHK("dbgack", 2'b10, r)
    `CHK("dbgmode", `CMSP_MODE_EXP, mode_o)
    wb(1'b0, `CMSP_OFS_STAT, 32'h0);
    `CHK("stat", {26'h0, 1'b1, 1'b0, `CMSP_MODE_EXP, 2'b11}, q)
    wb(1'b1, `CMSP_OFS_CTRL, 32'h0);
    instr(1'b0);
    `CHK("stop", 4'h0, clk_ctl_o[4:1])
    irq_i <= 1'b1;
    cyc(4);
    `CHK("stopirq", 4'h0, clk_ctl_o[4:1])
    irq_i <= 1'b0;
    ext_irq_i <= 1'b1;
    cyc(3);
    ext_irq_i <= 1'b0;
    `CHK("wake", 1'b1, clk_ctl_o.core_clk_en)
    wb(1'b1, `CMSP_OFS_CTRL, 32'h2);
    instr(1'b0);
    `CHK("pstop", 4'b1010, clk_ctl_o[4:1])
    tick_wdog_wake_i <= 1'b1;
    cyc(3);
    tick_wdog_wake_i <= 1'b0;
    `CHK("pwake", 1'b1, clk_ctl_o.core_clk_en)
    g = rnd() % 256;
    wb(1'b1, `CMSP_OFS_GATE, {24'h0, g});
    instr(1'b1);
    `CHK("hold", 1'b1, clk_ctl_o.core_bus_hold)
    `CHK("periph", 1'b1, clk_ctl_o.periph_en)
    `CHK("gates", ~g, periph_clk_en_o)
    irq_i <= 1'b1;
    cyc(3);
    irq_i <= 1'b0;
    `CHK("wwake", 1'b0, clk_ctl_o.core_bus_hold)
    wb(1'b1, `CMSP_OFS_CTRL, 32'h0);
    instr(1'b0);
    boot(`CMSP_MODE_SSC, 1'b1);
    `CHK("rstwake", 4'hf, clk_ctl_o[4:1])
    close_out();
  end
endmodule : tb_chip_mode_security_power_ctrl
